// ===== pwd_counter.sv
// ----------------------------------------------------------------
// watchdog up-counter with software load
// ----------------------------------------------------------------
`include "pwd_map.svh"

module pwd_counter
  import pwd_pkg::*;
#(
  parameter int WIDTH = `PWD_CNT_W
)
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             clear,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  input  wire logic             run,
  output logic      [WIDTH-1:0] count,
  output logic                  wrap
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  // refuse widths the wrap compare and load path cannot serve
  if (WIDTH < 2 || WIDTH > 32)
  begin : g_width_check
    $error("pwd_counter: WIDTH must lie in 2..32");
  end

  // a wrap is the overflow; it only counts when the counter is running
  assign wrap  = run && !load && !clear && (count_reg == {WIDTH{1'b1}});
  assign count = count_reg;

  // clear beats load, load beats counting
  always_comb
  begin
    count_next = count_reg;
    if (clear)
      count_next = '0;
    else if (load)
      count_next = load_val;
    else if (run)
      count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

endmodule : pwd_counter

// ===== pwd_map.svh
`ifndef PWD_MAP_SVH
`define PWD_MAP_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define PWD_ADDR_W        16
`define PWD_CSR_ADDR      16'hFFB1
`define PWD_CNT_ADDR      16'hFFB2
`define PWD_IST_ADDR      16'hFFB3
`define PWD_IEN_ADDR      16'hFFB4
`define PWD_ICLR_ADDR     16'hFFB5

// ----------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------
`define PWD_CNT_GUARD     7
`define PWD_CNT_WEN       6
`define PWD_REG_GUARD     5
`define PWD_REG_WEN       4
`define PWD_RUN_GUARD     3
`define PWD_RUN           2
`define PWD_OVF_GUARD     1
`define PWD_OVF_FLAG      0

// ----------------------------------------------------------------
// reset values and event bits
// ----------------------------------------------------------------
`define PWD_CNT_WEN_RST   1'h0
`define PWD_REG_WEN_RST   1'h0
`define PWD_RUN_RST       1'h1
`define PWD_OVF_FLAG_RST  1'h0
`define PWD_EV_W          2
`define PWD_EV_OVF        0
`define PWD_EV_REFUSED    1
`define PWD_EV_RST        2'h0
`define PWD_CNT_W         8

`endif

// ===== pwd_pkg.sv
`include "pwd_map.svh"

package pwd_pkg;

  // one register bus request, sampled on the clock edge
  typedef struct packed {
    logic [`PWD_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
    logic                   wr;
    logic                   rd;
  } pwd_bus_s;

  // protected control bits held by the block
  typedef struct packed {
    logic cnt_wen;
    logic reg_wen;
    logic run;
    logic ovf_flag;
  } pwd_ctrl_s;

endpackage : pwd_pkg

// ===== pwd_watchdog.sv
// Contract
// - counter write enable changes only when bit 7 is written 0
// - write-disable bits 7, 5, 3 and 1 always read as 1
// - counter takes software writes only while its write enable is 1
// - register write enable changes only when bit 5 is written 0
// - run bit and flag writable only while register write enable is 1
// - run bit changes only when bit 3 is written 0
// - counter increments while run is 1, holds while 0
// - run becomes 1 on a permitted write of 1, and on reset
// - run clears on a permitted write of 0 with its guard 0
// - overflow flag changes only when bit 1 is written 0
// - overflow makes an internal reset and sets the overflow flag
// - flag cleared only by the pin or a permitted software write of 0
// - the internal reset leaves the overflow flag set
//
// Chosen here: the plain strobed port.
`include "pwd_map.svh"

module pwd_watchdog
  import pwd_pkg::*;
#(
  parameter int CNT_W = `PWD_CNT_W
)
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire pwd_bus_s   bus,
  output logic      [7:0] rdata,
  input  wire logic       external_reset_pin_n,
  output logic            int_reset,
  output logic            irq,
  output logic            watchdog_run
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pwd_ctrl_s               ctrl_reg;
  pwd_ctrl_s               ctrl_next;
  logic [`PWD_EV_W-1:0]    ist_reg;
  logic [`PWD_EV_W-1:0]    ist_next;
  logic [`PWD_EV_W-1:0]    ien_reg;
  logic [`PWD_EV_W-1:0]    ien_next;
  logic [7:0]              rdata_reg;
  logic [7:0]              rdata_next;
  logic                    irq_reg;
  logic                    irq_next;
  logic                    intrst_reg;
  logic                    intrst_next;
  logic [1:0]              pin_sync_reg;
  logic [1:0]              pin_sync_next;
  logic                    ext_rst;
  logic                    csr_wr;
  logic                    cnt_wr;
  logic                    cnt_load;
  logic                    wrap;
  logic [CNT_W-1:0]        count;
  logic [7:0]              csr_view;
  logic [`PWD_EV_W-1:0]    events;
  logic [7:0]              w;

  // the count is loaded and read through the 8-bit data bus
  if (CNT_W < 2 || CNT_W > 8)
  begin : g_width_check
    $error("pwd_watchdog: CNT_W must lie in 2..8");
  end

  // ----------------------------------------------------------------
  // external reset pin synchroniser
  // ----------------------------------------------------------------
  // the pin is asynchronous; only the second stage is used by logic
  always_comb
  begin
    pin_sync_next = {pin_sync_reg[0], external_reset_pin_n};
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      pin_sync_reg <= 2'h3;
    else
      pin_sync_reg <= pin_sync_next;
  end

  assign ext_rst = !pin_sync_reg[1];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign w        = bus.wdata;
  assign csr_wr   = bus.wr && (bus.addr == `PWD_CSR_ADDR);
  assign cnt_wr   = bus.wr && (bus.addr == `PWD_CNT_ADDR);
  assign cnt_load = cnt_wr && ctrl_reg.cnt_wen;

  // guard bits always read back as ones
  assign csr_view = {1'b1, ctrl_reg.cnt_wen, 1'b1, ctrl_reg.reg_wen,
                     1'b1, ctrl_reg.run, 1'b1, ctrl_reg.ovf_flag};

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  pwd_counter #(
    .WIDTH    (CNT_W)
  ) u_counter (
    .clk      (clk),
    .srst     (srst),
    .clear    (ext_rst),
    .load     (cnt_load),
    .load_val (w[CNT_W-1:0]),
    .run      (ctrl_reg.run),
    .count    (count),
    .wrap     (wrap)
  );

  // ----------------------------------------------------------------
  // protected control bits
  // ----------------------------------------------------------------
  // each bit checks its own guard, run and flag also the register write enable, so one write can move several
  // bits; the overflow takes the bits back to reset values except flag
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (ext_rst)
    begin
      ctrl_next.cnt_wen  = `PWD_CNT_WEN_RST;
      ctrl_next.reg_wen  = `PWD_REG_WEN_RST;
      ctrl_next.run      = `PWD_RUN_RST;
      ctrl_next.ovf_flag = `PWD_OVF_FLAG_RST;
    end
    else if (wrap)
    begin
      ctrl_next.cnt_wen  = `PWD_CNT_WEN_RST;
      ctrl_next.reg_wen  = `PWD_REG_WEN_RST;
      ctrl_next.run      = `PWD_RUN_RST;
      ctrl_next.ovf_flag = 1'b1;
    end
    else if (csr_wr)
    begin
      if (!w[`PWD_CNT_GUARD])
        ctrl_next.cnt_wen = w[`PWD_CNT_WEN];
      if (!w[`PWD_REG_GUARD])
        ctrl_next.reg_wen = w[`PWD_REG_WEN];
      // run and flag use the register write enable held before this write
      if (ctrl_reg.reg_wen && !w[`PWD_RUN_GUARD])
        ctrl_next.run = w[`PWD_RUN];
      if (ctrl_reg.reg_wen && !w[`PWD_OVF_GUARD])
        ctrl_next.ovf_flag = w[`PWD_OVF_FLAG];
    end
  end

  // the flag's srst value stands for a power-on, which includes the pin
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_reg.cnt_wen  <= `PWD_CNT_WEN_RST;
      ctrl_reg.reg_wen  <= `PWD_REG_WEN_RST;
      ctrl_reg.run      <= `PWD_RUN_RST;
      ctrl_reg.ovf_flag <= `PWD_OVF_FLAG_RST;
    end
    else
      ctrl_reg <= ctrl_next;
  end

  // ----------------------------------------------------------------
  // events, interrupt and internal reset
  // ----------------------------------------------------------------
  always_comb
  begin
    events                  = '0;
    events[`PWD_EV_OVF]     = wrap;
    events[`PWD_EV_REFUSED] = cnt_wr && !ctrl_reg.cnt_wen;
  end

  // a new event wins over a clear written in the same cycle
  always_comb
  begin
    ist_next = ist_reg;
    ien_next = ien_reg;
    if (bus.wr && (bus.addr == `PWD_ICLR_ADDR))
      ist_next = ist_reg & ~w[`PWD_EV_W-1:0];
    ist_next = ist_next | events;
    if (bus.wr && (bus.addr == `PWD_IEN_ADDR))
      ien_next = w[`PWD_EV_W-1:0];
    irq_next    = |(ist_next & ien_next);
    intrst_next = wrap;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ist_reg    <= `PWD_EV_RST;
      ien_reg    <= `PWD_EV_RST;
      irq_reg    <= 1'b0;
      intrst_reg <= 1'b0;
    end
    else
    begin
      ist_reg    <= ist_next;
      ien_reg    <= ien_next;
      irq_reg    <= irq_next;
      intrst_reg <= intrst_next;
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_next = 8'h00;
    if (bus.rd)
    begin
      case (bus.addr)
        `PWD_CSR_ADDR: rdata_next = csr_view;
        `PWD_CNT_ADDR: rdata_next = 8'(count);
        `PWD_IST_ADDR: rdata_next = 8'(ist_reg);
        `PWD_IEN_ADDR: rdata_next = 8'(ien_reg);
        default:       rdata_next = 8'h00;   // unmapped and write-only
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  assign rdata        = rdata_reg;
  assign irq          = irq_reg;
  assign int_reset    = intrst_reg;
  assign watchdog_run = ctrl_reg.run;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  guard_reads_one_a: assert property (
    @(posedge clk) disable iff (srst)
    bus.rd && bus.addr == `PWD_CSR_ADDR
      |=> (rdata[7] && rdata[5] && rdata[3] && rdata[1]))
    else $error("guard bit read back as zero");

  cwen_guard_a: assert property (
    @(posedge clk) disable iff (srst)
    csr_wr && w[`PWD_CNT_GUARD] && !wrap && !ext_rst
      |=> $stable(ctrl_reg.cnt_wen))
    else $error("counter write enable moved with guard set");

  cnt_blocked_a: assert property (
    @(posedge clk) disable iff (srst)
    cnt_wr && !ctrl_reg.cnt_wen && !ctrl_reg.run && !ext_rst
      |=> $stable(count))
    else $error("counter took a write while locked");

  rwen_guard_a: assert property (
    @(posedge clk) disable iff (srst)
    csr_wr && w[`PWD_REG_GUARD] && !wrap && !ext_rst
      |=> $stable(ctrl_reg.reg_wen))
    else $error("register write enable moved with guard set");

  run_locked_a: assert property (
    @(posedge clk) disable iff (srst)
    csr_wr && !ctrl_reg.reg_wen && !wrap && !ext_rst
      |=> $stable(ctrl_reg.run) && $stable(ctrl_reg.ovf_flag))
    else $error("run or flag moved while register locked");

  count_hold_a: assert property (
    @(posedge clk) disable iff (srst)
    !ctrl_reg.run && !cnt_wr && !ext_rst |=> $stable(count))
    else $error("counter moved while stopped");

  count_step_a: assert property (
    @(posedge clk) disable iff (srst)
    ctrl_reg.run && !cnt_wr && !ext_rst
      |=> count == CNT_W'($past(count) + 1'b1))
    else $error("counter did not step while running");

  run_change_a: assert property (
    @(posedge clk) disable iff (srst)
    csr_wr && ctrl_reg.reg_wen && !w[`PWD_RUN_GUARD] && !wrap
      && !ext_rst |=> ctrl_reg.run == $past(w[`PWD_RUN]))
    else $error("permitted run write not taken");

  flag_guard_a: assert property (
    @(posedge clk) disable iff (srst)
    csr_wr && w[`PWD_OVF_GUARD] && !wrap && !ext_rst
      |=> $stable(ctrl_reg.ovf_flag))
    else $error("overflow flag moved with guard set");

  ovf_effect_a: assert property (
    @(posedge clk) disable iff (srst)
    wrap && !ext_rst |=> int_reset && ctrl_reg.ovf_flag ##1 !int_reset)
    else $error("overflow did not reset and flag");

  flag_kept_a: assert property (
    @(posedge clk) disable iff (srst)
    int_reset && !ext_rst && !csr_wr |=> ctrl_reg.ovf_flag)
    else $error("internal reset cleared the overflow flag");

  multi_bit_a: assert property (
    @(posedge clk) disable iff (srst)
    csr_wr && !w[`PWD_CNT_GUARD] && !w[`PWD_REG_GUARD] && !wrap
      && !ext_rst |=> ctrl_reg.cnt_wen == $past(w[`PWD_CNT_WEN])
      && ctrl_reg.reg_wen == $past(w[`PWD_REG_WEN]))
    else $error("one write failed to update two open bits");

endmodule : pwd_watchdog

// ===== tb.sv
`include "pwd_map.svh"

module tb
  import pwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals and instance
  // ----------------------------------------------------------------
  logic       clk;
  logic       srst;
  pwd_bus_s   bus;
  logic [7:0] rdata;
  logic       pin_n;
  logic       int_reset;
  logic       irq;
  logic       wd_run;
  int         failures;
  int         checked;
  logic [7:0] d;

  pwd_watchdog #(.CNT_W(8)) DUT
  (
    .clk                  (clk),
    .srst                 (srst),
    .bus                  (bus),
    .rdata                (rdata),
    .external_reset_pin_n (pin_n),
    .int_reset            (int_reset),
    .irq                  (irq),
    .watchdog_run         (wd_run)
  );

  // ----------------------------------------------------------------
  // clock, compare and bus helpers
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask : chk

  // one-cycle write strobe; the gap before the next request is harmless
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: 16'h0000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '{addr: 16'h0000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    #1 v = rdata;
  endtask : rd

  task automatic csr(input logic [7:0] exp);
    rd(`PWD_CSR_ADDR, d);
    chk("csr", exp, d);
  endtask : csr

  // bounded wait for the one-cycle overflow pulse
  task automatic wait_ovf(input int lim);
    int n;
    n = 0;
    while (int_reset !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk("int_reset", 8'h01, {7'h00, int_reset});
    @(posedge clk);
    #1 chk("int_reset pulse", 8'h00, {7'h00, int_reset});
  endtask : wait_ovf

  task automatic close_out;
    if (failures == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_guards;
    csr(8'hAE);
    chk("run pin", 8'h01, {7'h00, wd_run});
    wr(`PWD_CSR_ADDR, 8'hFF);
    csr(8'hAE);
    wr(`PWD_CSR_ADDR, 8'h9A);
    csr(8'hBE);
    wr(`PWD_CSR_ADDR, 8'hA2);
    csr(8'hBA);
    chk("run stop", 8'h00, {7'h00, wd_run});
    wr(`PWD_CSR_ADDR, 8'hAF);
    csr(8'hBA);
  endtask : t_guards

  task automatic t_counter;
    logic [7:0] c;
    wr(`PWD_CSR_ADDR, 8'h7F);
    csr(8'hFA);
    wr(`PWD_CNT_ADDR, 8'h10);
    rd(`PWD_CNT_ADDR, d);
    chk("cnt load", 8'h10, d);
    repeat (5) @(posedge clk);
    rd(`PWD_CNT_ADDR, d);
    chk("cnt hold", 8'h10, d);
    wr(`PWD_CSR_ADDR, 8'h3F);
    wr(`PWD_CNT_ADDR, 8'h55);
    rd(`PWD_CNT_ADDR, d);
    chk("cnt locked", 8'h10, d);
    rd(`PWD_IST_ADDR, d);
    chk("refused event", 8'h02, d);
    // one write opens the counter load and starts the count
    wr(`PWD_CSR_ADDR, 8'h66);
    csr(8'hFE);
    repeat (5) @(posedge clk);
    wr(`PWD_CSR_ADDR, 8'hA2);
    rd(`PWD_CNT_ADDR, c);
    // nine steps: the edge after the start write through the stop write
    chk("cnt run", 8'h19, c);
    rd(`PWD_CNT_ADDR, d);
    chk("cnt stopped", c, d);
  endtask : t_counter

  task automatic t_overflow;
    wr(`PWD_CNT_ADDR, 8'hF0);
    wr(`PWD_IEN_ADDR, 8'h01);
    wr(`PWD_ICLR_ADDR, 8'h03);
    wr(`PWD_CSR_ADDR, 8'hA6);
    wait_ovf(40);
    @(posedge clk);
    #1 chk("irq set", 8'h01, {7'h00, irq});
    csr(8'hAF);
    wr(`PWD_CSR_ADDR, 8'hAC);
    csr(8'hAF);
    wr(`PWD_ICLR_ADDR, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk("irq clear", 8'h00, {7'h00, irq});
  endtask : t_overflow

  task automatic t_pin_and_soft;
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (5) @(posedge clk);
    pin_n <= 1'b1;
    repeat (3) @(posedge clk);
    csr(8'hAE);
    // masked event must not raise the line until enabled
    wr(`PWD_IEN_ADDR, 8'h00);
    wait_ovf(300);
    @(posedge clk);
    #1 chk("irq masked", 8'h00, {7'h00, irq});
    csr(8'hAF);
    wr(`PWD_IEN_ADDR, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk("irq enabled", 8'h01, {7'h00, irq});
    wr(`PWD_CSR_ADDR, 8'h9A);
    csr(8'hBF);
    wr(`PWD_CSR_ADDR, 8'hBE);
    csr(8'hBF);
    wr(`PWD_CSR_ADDR, 8'hBC);
    csr(8'hBE);
    rd(16'h0000, d);
    chk("unmapped", 8'h00, d);
  endtask : t_pin_and_soft

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    failures = 0;
    checked = 0;
    srst = 1'b1;
    pin_n = 1'b1;
    bus = '{addr: 16'h0000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_guards();
    t_counter();
    t_overflow();
    t_pin_and_soft();
    close_out();
  end

  // the run needs well under 1000 cycles; this cuts a hang short
  initial
  begin
    #(40 * 5000);
    failures++;
    close_out();
  end
endmodule : tb
